// [logic/csr_defs.vh]
// Constants for the colour sensor range, timing and result logic
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// ==========================================================
// Clock and timebase
`define CSR_CLK_PERIOD_NS  4
`define CSR_TICK_NS        1000

// ==========================================================
// Range codes
`define CSR_RANGE_AUTO     4'hc
`define CSR_RANGE_MAX      4'h6
`define CSR_AUTO_RST       4'h6

// ==========================================================
// Result layout: exponent above a 20-bit mantissa
`define CSR_SCALE_MSB      23
`define CSR_SCALE_LSB      20
`define CSR_MANT_MSB       19
`define CSR_UPPER_LSB      8
`define CSR_LOWER_MSB      7
`define CSR_MANT_SAT       20'hfffff
`define CSR_ENTRY_RST      24'h000000
`define CSR_LIM_PAD        5'h08

// ==========================================================
// Auto-range decision points as fractions of full scale
`define CSR_AR_DN2_LIM     20'h10000
`define CSR_AR_DN1_LIM     20'h40000
`define CSR_AR_UP_LIM      20'he0000

// ==========================================================
// Per-channel conversion times in microseconds, codes 0 to 11
`define CSR_CT_US_0        20'h00258
`define CSR_CT_US_1        20'h003e8
`define CSR_CT_US_2        20'h00708
`define CSR_CT_US_3        20'h00d48
`define CSR_CT_US_4        20'h01964
`define CSR_CT_US_5        20'h0319c
`define CSR_CT_US_6        20'h061a8
`define CSR_CT_US_7        20'h0c350
`define CSR_CT_US_8        20'h186a0
`define CSR_CT_US_9        20'h30d40
`define CSR_CT_US_10       20'h61a80
`define CSR_CT_US_11       20'hc3500

`endif

// [logic/csr_result_mem.v]
// Result store: four committed channel entries, registered read port
`timescale 1ns/100ps
`include "csr_defs.vh"

module csr_result_mem (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        srst,
   // Write side, all four entries at once
   input  wire        wrAll,
   input  wire [95:0] wrData,
   // Read side
   input  wire [1:0]  rdAddr,
   output reg  [23:0] rdData
);

   reg [23:0] entry_reg [0:3];

   // ==========================================================
   // Storage
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : gEntry
         // Whole set is replaced together so a reader never sees a mixed measurement
         always @(posedge sys_clk) begin
            if (srst) begin
               entry_reg[i] <= `CSR_ENTRY_RST;
            end else if (wrAll) begin
               entry_reg[i] <= wrData[i*24 +: 24];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Registered read
   always @(posedge sys_clk) begin
      if (srst) begin
         rdData <= `CSR_ENTRY_RST;
      end else begin
         rdData <= entry_reg[rdAddr];
      end
   end

endmodule // csr_result_mem

// [logic/csr_range_result.v]
// Range selection, conversion sequencing, result forming and threshold compare
`timescale 1ns/100ps
`include "csr_defs.vh"

module csr_range_result #(
   parameter TICK_CYCLES = `CSR_TICK_NS / `CSR_CLK_PERIOD_NS
) (
   // Clock and reset
   sys_clk,
   srst,
   // Measurement control
   rangeSel,
   convTime,
   measStart,
   // Converter front end
   adcStart,
   adcEnd,
   adcChannel,
   adcScale,
   adcCode,
   adcOverRange,
   // Threshold settings
   limHighResult,
   limHighScale,
   limLowResult,
   limLowScale,
   limChannel,
   faultCount,
   // Status
   measBusy,
   measDone,
   faultHighFlag,
   faultLowFlag,
   expandedLimitHigh,
   expandedLimitLow,
   // Result read port
   rdChannel,
   channelScaleCode,
   channelUpperResult,
   channelLowerResult,
   channelLinearCode
);

   // Clock and reset
   input  wire        sys_clk;
   input  wire        srst;
   // Measurement control
   input  wire [3:0]  rangeSel;
   input  wire [3:0]  convTime;
   input  wire        measStart;
   // Converter front end
   output reg         adcStart;
   output reg         adcEnd;
   output reg  [1:0]  adcChannel;
   output reg  [3:0]  adcScale;
   input  wire [19:0] adcCode;
   input  wire        adcOverRange;
   // Threshold settings
   input  wire [11:0] limHighResult;
   input  wire [3:0]  limHighScale;
   input  wire [11:0] limLowResult;
   input  wire [3:0]  limLowScale;
   input  wire [1:0]  limChannel;
   input  wire [1:0]  faultCount;
   // Status
   output wire        measBusy;
   output reg         measDone;
   output reg         faultHighFlag;
   output reg         faultLowFlag;
   output reg  [35:0] expandedLimitHigh;
   output reg  [35:0] expandedLimitLow;
   // Result read port
   input  wire [1:0]  rdChannel;
   output reg  [3:0]  channelScaleCode;
   output reg  [11:0] channelUpperResult;
   output reg  [7:0]  channelLowerResult;
   output reg  [27:0] channelLinearCode;

   // ==========================================================
   // Sequencer states
   localparam [4:0] ST_IDLE   = 5'h01;
   localparam [4:0] ST_LAUNCH = 5'h02;
   localparam [4:0] ST_CONV   = 5'h04;
   localparam [4:0] ST_EVAL   = 5'h08;
   localparam [4:0] ST_COMMIT = 5'h10;
   // Prescaler end point, cut to the counter width on purpose
   localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
   localparam [11:0] TICK_LAST = TICK_LAST_FULL[11:0];

   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg  [11:0] tick_reg;
   reg  [19:0] usCnt_reg;
   reg  [19:0] convUs;
   reg  [3:0]  autoScale_reg [0:3];
   reg  [23:0] shadow_reg [0:3];
   reg  [3:0]  arNext;
   reg  [3:0]  hiCnt_reg;
   reg  [3:0]  loCnt_reg;
   reg  [3:0]  hiCnt_next;
   reg  [3:0]  loCnt_next;
   wire        autoMode;
   wire [3:0]  manualScale;
   wire [3:0]  launchScale;
   wire        tickEnd;
   wire        convEnd;
   wire        retry;
   wire [19:0] mantNew;
   wire        evalOk;
   wire [23:0] limEntry;
   wire [27:0] limLinear;
   wire        isHigh;
   wire        isLow;
   wire [3:0]  faultNeed;
   wire [35:0] limHighWide;
   wire [35:0] limLowWide;
   wire [23:0] memRd;

   // ==========================================================
   // Range selection
   // Code 0xC hands the choice to the per-channel auto state
   assign autoMode    = (rangeSel == `CSR_RANGE_AUTO);
   // Unlisted codes clamp to the widest fixed range rather than misbehave
   assign manualScale = (rangeSel > `CSR_RANGE_MAX) ? `CSR_RANGE_MAX : rangeSel;
   assign launchScale = autoMode ? autoScale_reg[adcChannel] : manualScale;

   // ==========================================================
   // Conversion time lookup, in microsecond ticks
   always @* begin
      case (convTime)
         4'h0:    convUs = `CSR_CT_US_0;
         4'h1:    convUs = `CSR_CT_US_1;
         4'h2:    convUs = `CSR_CT_US_2;
         4'h3:    convUs = `CSR_CT_US_3;
         4'h4:    convUs = `CSR_CT_US_4;
         4'h5:    convUs = `CSR_CT_US_5;
         4'h6:    convUs = `CSR_CT_US_6;
         4'h7:    convUs = `CSR_CT_US_7;
         4'h8:    convUs = `CSR_CT_US_8;
         4'h9:    convUs = `CSR_CT_US_9;
         4'ha:    convUs = `CSR_CT_US_10;
         default: convUs = `CSR_CT_US_11;
      endcase
   end

   // A microsecond prescaler keeps the long window counter narrow
   assign tickEnd = (tick_reg == TICK_LAST);
   assign convEnd = tickEnd && (usCnt_reg == convUs - 20'h00001);

   // ==========================================================
   // Evaluation of one channel conversion
   // Retry only in auto mode and only while a wider range is left
   assign retry   = autoMode && adcOverRange && (adcScale < `CSR_RANGE_MAX);
   // Over-range that cannot retry is reported as full-scale
   assign mantNew = adcOverRange ? `CSR_MANT_SAT : adcCode;
   assign evalOk  = (state_reg == ST_EVAL) && !retry;

   // Next auto range from this reading, fixed fractions of full scale
   always @* begin
      arNext = adcScale;
      if (adcOverRange) begin
         arNext = adcScale;
      end else if (adcCode < `CSR_AR_DN2_LIM) begin
         arNext = (adcScale > 4'h1) ? adcScale - 4'h2 : 4'h0;
      end else if (adcCode < `CSR_AR_DN1_LIM) begin
         arNext = (adcScale > 4'h0) ? adcScale - 4'h1 : 4'h0;
      end else if (adcCode >= `CSR_AR_UP_LIM) begin
         arNext = (adcScale < `CSR_RANGE_MAX) ? adcScale + 4'h1 : adcScale;
      end
   end

   // ==========================================================
   // Per-channel auto state and pending results
   genvar c;
   generate
      for (c = 0; c < 4; c = c + 1) begin : gChan
         // Only the channel just converted moves its own range
         always @(posedge sys_clk) begin
            if (srst) begin
               autoScale_reg[c] <= `CSR_AUTO_RST;
            end else if ((state_reg == ST_EVAL) && autoMode && (adcChannel == c)) begin
               autoScale_reg[c] <= retry ? adcScale + 4'h1 : arNext;
            end
         end
         // Held aside until all four succeed, so reads see the last full set
         always @(posedge sys_clk) begin
            if (srst) begin
               shadow_reg[c] <= `CSR_ENTRY_RST;
            end else if (evalOk && (adcChannel == c)) begin
               shadow_reg[c] <= {adcScale, mantNew};
            end
         end
      end
   endgenerate

   // ==========================================================
   // Sequencer next state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (measStart) begin
               state_next = ST_LAUNCH;
            end
         end
         ST_LAUNCH: begin
            state_next = ST_CONV;
         end
         ST_CONV: begin
            if (convEnd) begin
               state_next = ST_EVAL;
            end
         end
         ST_EVAL: begin
            // A retry reruns the same channel, stretching the measurement
            if (retry) begin
               state_next = ST_CONV;
            end else if (adcChannel == 2'h3) begin
               state_next = ST_COMMIT;
            end else begin
               state_next = ST_LAUNCH;
            end
         end
         ST_COMMIT: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Sequencer registers and converter strobes
   always @(posedge sys_clk) begin
      if (srst) begin
         state_reg  <= ST_IDLE;
         tick_reg   <= 12'h000;
         usCnt_reg  <= 20'h00000;
         adcStart   <= 1'b0;
         adcEnd     <= 1'b0;
         adcChannel <= 2'h0;
         adcScale   <= 4'h0;
         measDone   <= 1'b0;
      end else begin
         state_reg <= state_next;
         adcStart  <= 1'b0;
         adcEnd    <= 1'b0;
         measDone  <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               adcChannel <= 2'h0;
            end
            ST_LAUNCH: begin
               adcScale  <= launchScale;
               adcStart  <= 1'b1;
               tick_reg  <= 12'h000;
               usCnt_reg <= 20'h00000;
            end
            ST_CONV: begin
               if (tickEnd) begin
                  tick_reg  <= 12'h000;
                  usCnt_reg <= usCnt_reg + 20'h00001;
               end else begin
                  tick_reg <= tick_reg + 12'h001;
               end
               adcEnd <= convEnd;
            end
            ST_EVAL: begin
               if (retry) begin
                  // Step up once and convert again with no result kept
                  adcScale  <= adcScale + 4'h1;
                  adcStart  <= 1'b1;
                  tick_reg  <= 12'h000;
                  usCnt_reg <= 20'h00000;
               end else if (adcChannel != 2'h3) begin
                  adcChannel <= adcChannel + 2'h1;
               end
            end
            ST_COMMIT: begin
               measDone <= 1'b1;
            end
            default: begin
               adcChannel <= 2'h0;
            end
         endcase
      end
   end

   assign measBusy = (state_reg != ST_IDLE);

   // ==========================================================
   // Committed result store
   csr_result_mem uMem (
      .sys_clk (sys_clk),
      .srst    (srst),
      .wrAll   (state_reg == ST_COMMIT),
      .wrData  ({shadow_reg[3], shadow_reg[2], shadow_reg[1], shadow_reg[0]}),
      .rdAddr  (rdChannel),
      .rdData  (memRd)
   );

   // ==========================================================
   // Result fields, two cycles after the channel select
   always @(posedge sys_clk) begin
      if (srst) begin
         channelScaleCode   <= 4'h0;
         channelUpperResult <= 12'h000;
         channelLowerResult <= 8'h00;
         channelLinearCode  <= 28'h0000000;
      end else begin
         channelScaleCode   <= memRd[`CSR_SCALE_MSB:`CSR_SCALE_LSB];
         channelUpperResult <= memRd[`CSR_MANT_MSB:`CSR_UPPER_LSB];
         channelLowerResult <= memRd[`CSR_LOWER_MSB:0];
         // Exponent never passes 6 here, so 28 bits cannot overflow
         channelLinearCode  <= {8'h00, memRd[`CSR_MANT_MSB:0]}
                               << memRd[`CSR_SCALE_MSB:`CSR_SCALE_LSB];
      end
   end

   // ==========================================================
   // Threshold expansion and compare
   // Zero padding below the 12-bit field, 36 bits covers exponent 15
   assign limHighWide = {24'h000000, limHighResult}
                        << ({1'b0, limHighScale} + `CSR_LIM_PAD);
   assign limLowWide  = {24'h000000, limLowResult}
                        << ({1'b0, limLowScale} + `CSR_LIM_PAD);
   assign limEntry    = shadow_reg[limChannel];
   assign limLinear   = {8'h00, limEntry[`CSR_MANT_MSB:0]}
                        << limEntry[`CSR_SCALE_MSB:`CSR_SCALE_LSB];
   assign isHigh      = ({8'h00, limLinear} > limHighWide);
   assign isLow       = ({8'h00, limLinear} < limLowWide);
   assign faultNeed   = 4'h1 << faultCount;

   // Consecutive counters saturate at the needed count
   always @* begin
      hiCnt_next = 4'h0;
      loCnt_next = 4'h0;
      if (isHigh) begin
         hiCnt_next = (hiCnt_reg >= faultNeed) ? faultNeed : hiCnt_reg + 4'h1;
      end
      if (isLow) begin
         loCnt_next = (loCnt_reg >= faultNeed) ? faultNeed : loCnt_reg + 4'h1;
      end
   end

   // Flags move only on a committed measurement that completes the run
   always @(posedge sys_clk) begin
      if (srst) begin
         hiCnt_reg         <= 4'h0;
         loCnt_reg         <= 4'h0;
         faultHighFlag     <= 1'b0;
         faultLowFlag      <= 1'b0;
         expandedLimitHigh <= 36'h000000000;
         expandedLimitLow  <= 36'h000000000;
      end else begin
         expandedLimitHigh <= limHighWide;
         expandedLimitLow  <= limLowWide;
         if (state_reg == ST_COMMIT) begin
            hiCnt_reg <= hiCnt_next;
            loCnt_reg <= loCnt_next;
            if (hiCnt_next == faultNeed) begin
               faultHighFlag <= 1'b1;
               faultLowFlag  <= 1'b0;
            end else if (loCnt_next == faultNeed) begin
               faultHighFlag <= 1'b0;
               faultLowFlag  <= 1'b1;
            end
         end
      end
   end

endmodule // csr_range_result

// [tb/csr_range_result_monitor.sv]
// Concurrent checks on the ports of the range and result logic
`timescale 1ns/100ps
`include "csr_defs.vh"
// ==========================================================
// Checker
module csr_range_result_monitor (
   // Clock and reset
   input wire        sys_clk,
   input wire        srst,
   // Control
   input wire [3:0]  rangeSel,
   input wire        measStart,
   // Converter side
   input wire        adcStart,
   input wire        adcEnd,
   input wire [1:0]  adcChannel,
   input wire [3:0]  adcScale,
   input wire        adcOverRange,
   // Thresholds and status
   input wire [11:0] limHighResult,
   input wire [3:0]  limHighScale,
   input wire [35:0] expandedLimitHigh,
   input wire        measBusy,
   input wire        measDone,
   input wire        faultHighFlag,
   input wire        faultLowFlag
);
   reg  [3:0] lastScale_reg;
   reg  [1:0] lastCh_reg;
   wire       retryNow;
   default clocking cbMon @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // Keep the last evaluated channel and range; a retry must build on them
   always @(posedge sys_clk) begin
      if (adcEnd) begin
         lastScale_reg <= adcScale;
         lastCh_reg    <= adcChannel;
      end
   end
   // Over-range in auto mode below the top range means abort and retry
   assign retryNow = adcEnd && adcOverRange && rangeSel == `CSR_RANGE_AUTO
                     && adcScale < `CSR_RANGE_MAX;
   property p_retry;
      retryNow |-> ##[1:2] adcStart && adcScale == lastScale_reg + 4'h1
                           && adcChannel == lastCh_reg;
   endproperty
   a_retry: assert property (p_retry) else $error("retry did not raise range");
   property p_next;
      adcEnd && !retryNow && adcChannel != 2'h3 |-> ##[1:2] adcStart
         && adcChannel == lastCh_reg + 2'h1;
   endproperty
   a_next: assert property (p_next) else $error("channels not in turn");
   property p_commit;
      adcEnd && !retryNow && adcChannel == 2'h3 |-> ##2 measDone;
   endproperty
   a_commit: assert property (p_commit) else $error("no commit after last channel");
   property p_fixed;
      adcStart && rangeSel <= `CSR_RANGE_MAX |-> adcScale == rangeSel;
   endproperty
   a_fixed: assert property (p_fixed) else $error("manual range not used");
   property p_top;
      adcStart |-> adcScale <= `CSR_RANGE_MAX;
   endproperty
   a_top: assert property (p_top) else $error("range above top");
   property p_take;
      measStart && !measBusy |=> measBusy;
   endproperty
   a_take: assert property (p_take) else $error("start not taken");
   property p_done;
      measDone |-> !measBusy ##1 !measDone;
   endproperty
   a_done: assert property (p_done) else $error("done not a single idle pulse");
   property p_end;
      $fell(measBusy) && !$past(srst) |-> measDone;
   endproperty
   a_end: assert property (p_end) else $error("busy fell without done");
   property p_lim;
      !$past(srst) |-> expandedLimitHigh
         == ({24'h000000, $past(limHighResult)} << (8 + $past(limHighScale)));
   endproperty
   a_lim: assert property (p_lim) else $error("high limit expansion wrong");
   property p_excl;
      !(faultHighFlag && faultLowFlag);
   endproperty
   a_excl: assert property (p_excl) else $error("both fault flags set");
   property p_flag;
      ($changed(faultHighFlag) || $changed(faultLowFlag)) && !$past(srst) |-> measDone;
   endproperty
   a_flag: assert property (p_flag) else $error("flag moved outside commit");
endmodule // csr_range_result_monitor

bind csr_range_result csr_range_result_monitor uMon (
   .sys_clk(sys_clk), .srst(srst), .rangeSel(rangeSel), .measStart(measStart),
   .adcStart(adcStart), .adcEnd(adcEnd), .adcChannel(adcChannel), .adcScale(adcScale),
   .adcOverRange(adcOverRange), .limHighResult(limHighResult),
   .limHighScale(limHighScale), .expandedLimitHigh(expandedLimitHigh),
   .measBusy(measBusy), .measDone(measDone), .faultHighFlag(faultHighFlag),
   .faultLowFlag(faultLowFlag)
);

// [tb/csr_adc_model.sv]
// Converter front-end model: a light level and a needed range per channel
`timescale 1ns/100ps
// ==========================================================
// Front-end model
module csr_adc_model (
   // Converter handshake
   input  wire        adcEnd,
   input  wire [1:0]  adcChannel,
   input  wire [3:0]  adcScale,
   // Scene from the bench
   input  wire [79:0] sceneCode,
   input  wire [15:0] sceneScale,
   // Answer
   output wire [19:0] adcCode,
   output wire        adcOverRange
);
   wire [19:0] codeNow;
   wire        overNow;
   // Light too strong for the range in use gives over-range
   assign codeNow = sceneCode[adcChannel*20 +: 20];
   assign overNow = adcScale < sceneScale[adcChannel*4 +: 4];
   // Outside the evaluation cycle the lines carry the inverse, so a late sample shows
   assign adcCode      = adcEnd ? codeNow : ~codeNow;
   assign adcOverRange = adcEnd ? overNow : ~overNow;
endmodule // csr_adc_model

// [tb/csr_range_result_bench.sv]
// Self-checking bench for the range, sequencing and threshold logic
`timescale 1ns/100ps
// ==========================================================
// Bench top
module csr_range_result_bench;
   localparam TICK = 1; // One cycle per microsecond keeps windows short
   reg         sys_clk, srst, measStart;
   reg  [3:0]  rangeSel, convTime, limHighScale, limLowScale;
   reg  [11:0] limHighResult, limLowResult;
   reg  [1:0]  limChannel, faultCount, rdChannel;
   reg  [79:0] sceneCode;
   reg  [15:0] sceneScale;
   wire        adcStart, adcEnd, adcOverRange, measBusy, measDone, faultHighFlag, faultLowFlag;
   wire [1:0]  adcChannel;
   wire [3:0]  adcScale, channelScaleCode;
   wire [19:0] adcCode;
   wire [35:0] expandedLimitHigh, expandedLimitLow;
   wire [11:0] channelUpperResult;
   wire [7:0]  channelLowerResult;
   wire [27:0] channelLinearCode;
   integer     errorCnt, testsRun, cycles, n, r, c;
   integer     usTab [0:5] = '{600, 1000, 1800, 3400, 6500, 12700};
   // ==========================================================
   // Design and front end
   csr_range_result #(.TICK_CYCLES(TICK)) uut (
      .sys_clk(sys_clk), .srst(srst), .rangeSel(rangeSel), .convTime(convTime),
      .measStart(measStart), .adcStart(adcStart), .adcEnd(adcEnd), .adcChannel(adcChannel),
      .adcScale(adcScale), .adcCode(adcCode), .adcOverRange(adcOverRange),
      .limHighResult(limHighResult), .limHighScale(limHighScale),
      .limLowResult(limLowResult), .limLowScale(limLowScale), .limChannel(limChannel),
      .faultCount(faultCount), .measBusy(measBusy), .measDone(measDone),
      .faultHighFlag(faultHighFlag), .faultLowFlag(faultLowFlag),
      .expandedLimitHigh(expandedLimitHigh), .expandedLimitLow(expandedLimitLow),
      .rdChannel(rdChannel), .channelScaleCode(channelScaleCode),
      .channelUpperResult(channelUpperResult), .channelLowerResult(channelLowerResult),
      .channelLinearCode(channelLinearCode));
   csr_adc_model uFront (
      .adcEnd(adcEnd), .adcChannel(adcChannel), .adcScale(adcScale), .sceneCode(sceneCode),
      .sceneScale(sceneScale), .adcCode(adcCode), .adcOverRange(adcOverRange));
   // ==========================================================
   // Clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Whole run is about 70000 cycles; a hang is cut off well above that
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 90000) begin
         errorCnt = errorCnt + 1;
         $display("BAD run timed out");
         endSim;
      end
   end
   // ==========================================================
   // Shared tasks
   task tick;
      begin
         @(posedge sys_clk);
         #0.5;
      end
   endtask
   task chk(input string nm, input [35:0] expV, input [35:0] gotV);
      begin
         testsRun = testsRun + 1;
         if (gotV !== expV) begin
            errorCnt = errorCnt + 1;
            $display("BAD %s expected %h seen %h", nm, expV, gotV);
         end
      end
   endtask
   task rst;
      begin
         srst = 1'b1;
         repeat (2) tick;
         srst = 1'b0;
      end
   endtask
   task go;
      begin
         measStart = 1'b1;
         tick;
         measStart = 1'b0;
      end
   endtask
   // Bounded wait for the commit pulse, counting cycles
   task waitDone;
      begin
         n = 0;
         while (measDone !== 1'b1 && n < 20000) begin
            tick;
            n = n + 1;
         end
         chk("measDone", 36'h1, {35'h0, measDone});
         tick;
      end
   endtask
   task meas;
      begin
         go;
         waitDone;
      end
   endtask
   // Read one channel; read pipe is two edges deep
   task rdchk(input [1:0] ch, input [3:0] sc, input [19:0] mt);
      begin
         rdChannel = ch;
         repeat (3) tick;
         chk("scale", {32'h0, sc}, {32'h0, channelScaleCode});
         chk("upper", {24'h0, mt[19:8]}, {24'h0, channelUpperResult});
         chk("lower", {28'h0, mt[7:0]}, {28'h0, channelLowerResult});
         chk("linear", {8'h00, mt} << sc, {8'h00, channelLinearCode});
      end
   endtask
   task chkAll(input [15:0] sc);
      for (c = 0; c < 4; c = c + 1) rdchk(c[1:0], sc[c*4 +: 4], sceneCode[c*20 +: 20]);
   endtask
   // ==========================================================
   // Scenarios
   task t_fixed;
      begin
         sceneCode = {20'h80000, 20'h00001, 20'habcde, 20'h12345};
         for (r = 0; r < 7; r = r + 1) begin
            rangeSel = r[3:0];
            go;
            // Mid-measurement read still shows the previous set
            rdchk(2'h0, (r == 0) ? 4'h0 : 4'(r - 1), (r == 0) ? 20'h0 : 20'h12345);
            waitDone;
            chk("duration", 36'h1, {35'h0, n >= 2400 && n <= 2412});
            chkAll({4{r[3:0]}});
         end
         $display("t_fixed done");
      end
   endtask
   task t_auto;
      begin
         rst;
         rangeSel = 4'hc;
         sceneCode = {20'h80000, 20'hf0000, 20'h20000, 20'h08000};
         meas;
         chkAll(16'h6666);
         meas;
         chkAll(16'h6654);
         sceneCode[19:0] = 20'hf0000;
         meas;
         chkAll(16'h6642);
         $display("t_auto done");
      end
   endtask
   task t_over;
      begin
         sceneScale = 16'h0760;
         meas;
         chk("retry time", 36'h1, {35'h0, n >= 4200});
         rdchk(2'h0, 4'h3, 20'hf0000);
         rdchk(2'h1, 4'h6, 20'h20000);
         rdchk(2'h2, 4'h6, 20'hfffff);
         rangeSel = 4'h2;
         meas;
         rdchk(2'h1, 4'h2, 20'hfffff);
         rdchk(2'h3, 4'h2, 20'h80000);
         sceneScale = 16'h0000;
         $display("t_over done");
      end
   endtask
   task t_limit;
      begin
         {limHighResult, limHighScale, limLowResult, limLowScale} = 32'habc0_ffff;
         repeat (2) tick;
         chk("limHigh", {24'h0, 12'habc} << 8, expandedLimitHigh);
         chk("limLow", {24'h0, 12'hfff} << 23, expandedLimitLow);
         {limHighResult, limHighScale} = 16'h0018;
         repeat (2) tick;
         chk("limHigh", 36'h000010000, expandedLimitHigh);
         $display("t_limit done");
      end
   endtask
   task t_fault;
      begin
         rst;
         {rangeSel, limChannel, faultCount} = 8'h00;
         sceneCode = {4{20'h00100}};
         {limHighResult, limHighScale, limLowResult, limLowScale} = 32'h0010_0000;
         meas;
         chk("high at equal", 36'h0, {35'h0, faultHighFlag});
         limHighResult = 12'h000;
         faultCount = 2'h1;
         meas;
         chk("high after one", 36'h0, {35'h0, faultHighFlag});
         meas;
         chk("high after two", 36'h1, {35'h0, faultHighFlag});
         // High limit back above the reading so only the low side faults
         {limHighResult, limLowResult, faultCount} = 26'h03fc080;
         meas;
         chk("low flags", 36'h1, {34'h0, faultHighFlag, faultLowFlag});
         $display("t_fault done");
      end
   endtask
   task t_conv;
      begin
         for (r = 0; r < 6; r = r + 1) begin
            rst;
            convTime = r[3:0];
            go;
            n = 0;
            while (adcStart !== 1'b1 && n < 10) begin
               tick;
               n = n + 1;
            end
            n = 0;
            while (adcEnd !== 1'b1 && n < 20000) begin
               tick;
               n = n + 1;
            end
            chk("window", usTab[r] * TICK, n);
         end
         rst;
         $display("t_conv done");
      end
   endtask
   // ==========================================================
   // Verdict
   task endSim;
      begin
         $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
         if (errorCnt == 0 && testsRun > 0) begin
            $display("All tests passed");
         end else begin
            $display("Some tests failed");
         end
         $finish;
      end
   endtask
   initial begin
      {errorCnt, testsRun, cycles} = 96'h0;
      {srst, measStart, rdChannel, limChannel, faultCount} = 8'h80;
      {rangeSel, convTime, limHighScale, limLowScale} = 16'h0000;
      {limHighResult, limLowResult, sceneCode, sceneScale} = 120'h0;
      repeat (5) tick;
      srst = 1'b0;
      t_fixed;
      t_auto;
      t_over;
      t_limit;
      t_fault;
      t_conv;
      endSim;
   end
endmodule // csr_range_result_bench
